// [shared/dfc_pkg.sv]
// package for the debug counter freeze control block
package dfc_pkg;
  // register map (word aligned, byte addresses)
  localparam logic [7:0]  FREEZE_CTRL_ADDR  = 8'h00;
  localparam logic [7:0]  DEBUG_STATUS_ADDR = 8'h04;
  localparam logic [31:0] FREEZE_CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] FREEZE_CTRL_MASK  = 32'h0000_077f;
  // field positions of the freeze control register
  localparam int ADV_TIMER_BIT   = 0;
  localparam int GEN_TIMER1_BIT  = 1;
  localparam int GEN_TIMER2_BIT  = 2;
  localparam int GEN_TIMER3_BIT  = 3;
  localparam int GEN_TIMER4_BIT  = 4;
  localparam int BASIC_GRP_BIT   = 5;
  localparam int WAKEUP_BIT      = 6;
  localparam int RTC_BIT         = 8;
  localparam int IND_WDOG_BIT    = 9;
  localparam int WIN_WDOG_BIT    = 10;
  // status register field positions
  localparam int ST_HALTED_BIT   = 0;
  localparam int ST_AVAIL_BIT    = 1;
  localparam int ST_CLKOFF_BIT   = 2;
  localparam int ST_DEEP_BIT     = 3;
  localparam int NUM_CNT         = 12;

  // count enables toward the peripheral counters
  typedef struct packed {
    logic       win_wdog;
    logic       ind_wdog;
    logic       rtc;
    logic       wakeup;
    logic [2:0] basic;
    logic       gen4;
    logic       gen3;
    logic       gen2;
    logic       gen1;
    logic       adv;
  } dfc_cnt_en_s;

  typedef enum logic [1:0] {
    DFC_IDLE,
    DFC_ACK
  } dfc_bus_e;
endpackage

// [hw/dfc_top.sv]
// debug counter freeze control with classic wishbone register slave
// What this block does
// - bit 10 freezes windowed watchdog when halted
// - bit 9 freezes independent watchdog when halted
// - bit 8 freezes real-time clock when halted
// - bit 6 freezes auto-wakeup timer when halted
// - bit 5 freezes all three basic timers
// - bit 4 freezes general timer four
// - bit 3 freezes general timer three
// - bit 2 freezes general timer two
// - bit 1 freezes general timer one
// - bit 0 freezes advanced timer
// - debug fails once core clock is gated
// - deepest sleep makes debug access port dead
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module dfc_top
  import dfc_pkg::*;
(
  input  wire logic         clk_i,         // core clock, 250 MHz
  input  wire logic         rst_i,         // sync reset, active high
  input  wire logic         wb_cyc_i,      // wishbone cycle
  input  wire logic         wb_stb_i,      // wishbone strobe
  input  wire logic         wb_we_i,       // wishbone write
  input  wire logic [7:0]   wb_adr_i,      // byte address
  input  wire logic [3:0]   wb_sel_i,      // byte lanes
  input  wire logic [31:0]  wb_dat_i,      // write data
  output logic      [31:0]  wb_dat_o,      // read data
  output logic              wb_ack_o,      // ack pulse
  input  wire logic         core_halted_i, // core halted in debug (pin)
  input  wire logic         wfi_gate_i,    // core clock gated by wfi
  input  wire logic         deep_sleep_i,  // chip in deepest sleep
  input  wire logic [11:0]  cnt_run_i,     // counters' own enables
  output dfc_cnt_en_s       cnt_en_o,      // gated count enables
  output logic              dbg_avail_o    // debug access usable
);
  import dfc_pkg::*;

  typedef struct packed {
    dfc_bus_e     bus;
    logic [31:0]  ctrl;
    logic [31:0]  rdat;
    logic         ack;
    logic [1:0]   halt_sync;
    logic [1:0]   wfi_sync;
    logic [1:0]   deep_sync;
    dfc_cnt_en_s  en;
    logic         avail;
  } dfc_state_s;

  dfc_state_s state_r;
  dfc_state_s state_nxt;

  // byte-lane merge, used for the control register write
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // one freeze decision: stall only while halted and the bit is set
  function automatic logic gate(input logic run, input logic halted,
                                input logic frz);
    return run & ~(halted & frz);
  endfunction

  logic        halted;
  logic [31:0] c;

  // next state: synchronisers, bus slave and counter gating
  always_comb begin
    state_nxt = state_r;
    halted    = state_r.halt_sync[1];
    c         = state_r.ctrl;
    // second flop only is read below; first flop feeds nothing else
    state_nxt.halt_sync = {state_r.halt_sync[0], core_halted_i};
    state_nxt.wfi_sync  = {state_r.wfi_sync[0], wfi_gate_i};
    state_nxt.deep_sync = {state_r.deep_sync[0], deep_sleep_i};

    // bus: answer one cycle after the request, drop ack next cycle
    state_nxt.ack = 1'b0;
    case (state_r.bus)
      DFC_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          state_nxt.ack  = 1'b1;
          state_nxt.bus  = DFC_ACK;
          state_nxt.rdat = 32'h0000_0000; // unmapped reads zero
          if (wb_we_i) begin
            if (wb_adr_i == FREEZE_CTRL_ADDR) begin
              state_nxt.ctrl = lane_merge(state_r.ctrl, wb_dat_i,
                                          wb_sel_i) & FREEZE_CTRL_MASK;
            end
          end else if (wb_adr_i == FREEZE_CTRL_ADDR) begin
            state_nxt.rdat = state_r.ctrl;
          end else if (wb_adr_i == DEBUG_STATUS_ADDR) begin
            state_nxt.rdat[ST_HALTED_BIT] = halted;
            state_nxt.rdat[ST_AVAIL_BIT]  = state_r.avail;
            state_nxt.rdat[ST_CLKOFF_BIT] = state_r.wfi_sync[1];
            state_nxt.rdat[ST_DEEP_BIT]   = state_r.deep_sync[1];
          end
        end
      end
      DFC_ACK: begin
        state_nxt.bus = DFC_IDLE; // master releases after ack
      end
      default: begin
        state_nxt.bus = DFC_IDLE;
      end
    endcase

    // per-counter gating; halt release resumes from held value
    state_nxt.en.win_wdog = gate(cnt_run_i[11], halted,
                                 c[WIN_WDOG_BIT]);
    state_nxt.en.ind_wdog = gate(cnt_run_i[10], halted,
                                 c[IND_WDOG_BIT]);
    state_nxt.en.rtc      = gate(cnt_run_i[9], halted,
                                 c[RTC_BIT]);
    state_nxt.en.wakeup   = gate(cnt_run_i[8], halted,
                                 c[WAKEUP_BIT]);
    for (int k = 0; k < 3; k++) begin
      state_nxt.en.basic[k] = gate(cnt_run_i[5+k], halted,
                                   c[BASIC_GRP_BIT]);
    end
    state_nxt.en.gen4 = gate(cnt_run_i[4], halted,
                             c[GEN_TIMER4_BIT]);
    state_nxt.en.gen3 = gate(cnt_run_i[3], halted,
                             c[GEN_TIMER3_BIT]);
    state_nxt.en.gen2 = gate(cnt_run_i[2], halted,
                             c[GEN_TIMER2_BIT]);
    state_nxt.en.gen1 = gate(cnt_run_i[1], halted,
                             c[GEN_TIMER1_BIT]);
    state_nxt.en.adv  = gate(cnt_run_i[0], halted,
                             c[ADV_TIMER_BIT]);

    // debug link needs the core clock and is dead in deepest sleep
    state_nxt.avail = ~state_r.wfi_sync[1]
                    & ~state_r.deep_sync[1];
  end

  // the whole state registers here; reset gives constants only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r      <= '0;
      state_r.bus  <= DFC_IDLE;
      state_r.ctrl <= FREEZE_CTRL_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign wb_dat_o    = state_r.rdat;
  assign wb_ack_o    = state_r.ack;
  assign cnt_en_o    = state_r.en;
  assign dbg_avail_o = state_r.avail;
endmodule

// [tb/dfc_properties.sv]
// port assertions for the freeze control block
`timescale 1ns/1ps
module dfc_properties
  import dfc_pkg::*;
(
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_ack_o,
  input wire logic                 wfi_gate_i,
  input wire logic                 deep_sleep_i,
  input wire logic                 core_halted_i,
  input wire logic [11:0]          cnt_run_i,
  input wire dfc_pkg::dfc_cnt_en_s cnt_en_o,
  input wire logic                 dbg_avail_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus: answer in the next cycle, one cycle wide, never unasked
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o
    && !$past(wb_ack_o) |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  // gating may only remove enables, never add one
  property p_run_cap; !$past(rst_i) |->
    (cnt_en_o & ~$past(cnt_run_i)) == 12'h000; endproperty
  a_run_cap: assert property (p_run_cap) else $error("enable added");
  // two sampled cycles of no halt cover either latency reading
  property p_free_run; !$past(rst_i) && !$past(core_halted_i, 2) &&
    !$past(core_halted_i, 3) |-> cnt_en_o == $past(cnt_run_i); endproperty
  a_free_run: assert property (p_free_run) else $error("frozen free");
  property p_avail_wfi; $past(wfi_gate_i, 2) && $past(wfi_gate_i, 3)
    |-> !dbg_avail_o; endproperty
  a_avail_wfi: assert property (p_avail_wfi) else $error("avail wfi");
  property p_avail_deep; $past(deep_sleep_i, 2) && $past(deep_sleep_i, 3)
    |-> !dbg_avail_o; endproperty
  a_avail_deep: assert property (p_avail_deep) else $error("avail deep");
  property p_avail_up; !$past(rst_i, 3) && !$past(rst_i) &&
    !$past(wfi_gate_i | deep_sleep_i, 2) &&
    !$past(wfi_gate_i | deep_sleep_i, 3) |-> dbg_avail_o; endproperty
  a_avail_up: assert property (p_avail_up) else $error("avail low");
endmodule
bind dfc_top dfc_properties dfc_properties_i (.*);

// [tb/dfc_dbg_model.sv]
// debugger and core model: halts and resumes after a lag
`timescale 1ns/1ps
module dfc_dbg_model (
  input  wire logic       clk_i,      // core clock
  input  wire logic       rst_i,      // sync reset
  input  wire logic       halt_req_i, // debugger asks for a halt
  input  wire logic [3:0] lag_i,      // answer delay in cycles
  output logic            halted_o    // core halted in debug
);
  logic [3:0] cnt_r;
  // a real core does not stop at once, so the answer lags
  always @(posedge clk_i) begin
    cnt_r <= (rst_i || halt_req_i == halted_o) ? 4'h0 : cnt_r + 4'h1;
    if (rst_i)
      halted_o <= 1'b0;
    else if (halt_req_i != halted_o && cnt_r >= lag_i)
      halted_o <= halt_req_i;
  end
endmodule

// [tb/tb_dfc_top.sv]
// self-checking bench for the freeze control block
`timescale 1ns/1ps
module tb_dfc_top;
  import dfc_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, req = 0, wait_for_interrupt_instruction = 0, deep = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0, lag = 0;
  logic [31:0] wdat = 0, rdat, dat_o;
  logic [11:0] run = 0;
  logic [11:0] cm [10] = '{12'h1, 12'h2, 12'h4, 12'h8, 12'h10, 12'he0,
                           12'h100, 12'h200, 12'h400, 12'h800};
  logic ack, halted, avail;
  dfc_cnt_en_s en;
  int failures = 0, n_checks = 0;
  dfc_top dfc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .core_halted_i(halted), .wfi_gate_i(wait_for_interrupt_instruction), .deep_sleep_i(deep),
    .cnt_run_i(run), .cnt_en_o(en), .dbg_avail_o(avail));
  dfc_dbg_model dfc_dbg_model_i (.clk_i(clk_i), .rst_i(rst_i),
    .halt_req_i(req), .lag_i(lag), .halted_o(halted));
  always #2 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic cycle; the next call leaves an idle cycle first
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rdat = dat_o;
    cyc <= 0;
  endtask
  task automatic summarize;
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    wb(0, FREEZE_CTRL_ADDR, 4'hf, 0);
    chk("ctrl_rst", rdat, FREEZE_CTRL_RST);
    wb(1, FREEZE_CTRL_ADDR, 4'hf, 32'hffff_ffff);
    wb(1, FREEZE_CTRL_ADDR, 4'h2, 32'h0);
    wb(0, FREEZE_CTRL_ADDR, 4'hf, 0);
    chk("ctrl_mask", rdat, FREEZE_CTRL_MASK & 32'h0000_00ff);
    wb(0, 8'h08, 4'hf, 0);
    chk("unmapped", rdat, 32'h0);
    // a write to an unmapped word must leave the control register alone
    wb(1, 8'h08, 4'hf, 32'h0);
    wb(0, FREEZE_CTRL_ADDR, 4'hf, 0);
    chk("unmapped_wr", rdat, FREEZE_CTRL_MASK & 32'h0000_00ff);
    run <= 12'hfff;
    // one freeze bit at a time, with a slower core each round
    for (int i = 0; i < 10; i++) begin
      wb(1, FREEZE_CTRL_ADDR, 4'hf, 32'h1 << (i > 6 ? i + 1 : i));
      chk("free", 32'(en), 32'hfff);
      lag <= i[3:0];
      req <= 1;
      while (halted !== 1'b1) @(posedge clk_i);
      repeat (5) @(posedge clk_i);
      chk("frozen", 32'(en), {20'h0, ~cm[i]});
      wb(0, DEBUG_STATUS_ADDR, 4'hf, 0);
      chk("status", rdat, 32'h3);
      req <= 0;
      repeat (8 + i) @(posedge clk_i);
      chk("resumed", 32'(en), 32'hfff);
    end
    // enables must follow the counters' own settings outside a halt
    run <= 12'ha5a;
    repeat (2) @(posedge clk_i);
    chk("own_run", 32'(en), 32'ha5a);
    wait_for_interrupt_instruction <= 1;
    repeat (5) @(posedge clk_i);
    chk("avail_wfi", 32'(avail), 32'h0);
    wb(0, DEBUG_STATUS_ADDR, 4'hf, 0);
    chk("status_wfi", rdat, 32'h4);
    wait_for_interrupt_instruction <= 0;
    // deepest sleep is exercised last, after all other debug work
    deep <= 1;
    repeat (5) @(posedge clk_i);
    chk("avail_deep", 32'(avail), 32'h0);
    wb(0, DEBUG_STATUS_ADDR, 4'hf, 0);
    chk("status_deep", rdat, 32'h8);
    deep <= 0;
    repeat (5) @(posedge clk_i);
    chk("avail_up", 32'(avail), 32'h1);
    summarize();
  end
  // the tests need well under 2000 cycles
  initial begin
    #20000;
    failures++;
    summarize();
  end
endmodule
